/* File: pkg/trc_pkg.sv */
// Shared constants for the timer run-control block: register map,
// field positions, reset values and the count clock select codes.
// Assumes an 8-bit register port and a single 25 MHz system clock.

package trc_pkg;

  // ****************************************
  // Bus and counter widths
  // ****************************************
  localparam int TRC_AW = 8;
  localparam int TRC_DW = 8;
  localparam int TRC_CNT_W = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [TRC_AW-1:0] TRC_OFS_RUN = 8'h00;
  localparam logic [TRC_AW-1:0] TRC_OFS_CNT_LO = 8'h01;
  localparam logic [TRC_AW-1:0] TRC_OFS_CNT_HI = 8'h02;
  localparam logic [TRC_AW-1:0] TRC_OFS_OUT_CFG = 8'h03;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int TRC_BIT_PAUSE = 7;
  localparam int TRC_BIT_SEL_HI = 6;
  localparam int TRC_BIT_SEL_LO = 4;
  localparam int TRC_BIT_ON = 3;
  localparam int TRC_BIT_INIT = 0;
  localparam int TRC_BIT_CMP = 1;
  localparam int TRC_BIT_PIN = 2;
  localparam logic [TRC_DW-1:0] TRC_RUN_MASK = 8'hf8;
  localparam logic [TRC_DW-1:0] TRC_RUN_RST = 8'h00;
  localparam logic [1:0] TRC_CFG_RST = 2'h0;
  localparam logic [TRC_DW-1:0] TRC_RD_ZERO = 8'h00;

  // ****************************************
  // Count clock selection
  // ****************************************
  localparam int TRC_SYS_DIV = 4;
  localparam logic [1:0] TRC_DIV_LAST = 2'(TRC_SYS_DIV - 1);

  typedef enum logic [2:0] {
    TRC_CK_SYS_DIV4 = 3'h0,
    TRC_CK_SYS = 3'h1,
    TRC_CK_HIGH_DIV16 = 3'h2,
    TRC_CK_HIGH_DIV64 = 3'h3,
    TRC_CK_TBC = 3'h4,
    TRC_CK_RSVD = 3'h5,
    TRC_CK_EXT_RISE = 3'h6,
    TRC_CK_EXT_FALL = 3'h7
  } trc_clk_sel_t;

endpackage

/* File: pkg/trc_clk_if.sv */
// Carries the count clock request and the resulting tick between the
// run-control core and the clock selector. All signals on one clock.
`timescale 1ns/100ps

interface trc_clk_if import trc_pkg::*; ;
  trc_clk_sel_t sel; // Selected count source
  logic enable; // Module on
  logic high_div16_tick; // High clock /16 enable pulse
  logic high_div64_tick; // High clock /64 enable pulse
  logic tbc_tick; // Time-base enable pulse
  logic ext_level; // Synchronised external pin
  logic count_tick; // One-cycle count enable

  modport core (output sel, enable, high_div16_tick, high_div64_tick,
                output tbc_tick, ext_level, input count_tick);
  modport selector (input sel, enable, high_div16_tick, high_div64_tick,
                    input tbc_tick, ext_level, output count_tick);
endinterface

/* File: core/trc_clk_sel.sv */
// Count clock selector: system clock divider, internal tick pick-up
// and external pin edge detection, giving a one-cycle count enable.
// Assumes the external level is already synchronised by the caller.
`timescale 1ns/100ps

module trc_clk_sel import trc_pkg::*; (
  input wire logic clock, // System clock
  input wire logic rst_n, // Async reset, active low
  trc_clk_if.selector cif // Selection and tick
);

  // ****************************************
  // Divider and edge history
  // ****************************************
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic ext_prev_r;
  logic ext_prev_nxt;
  logic div_tick;
  logic pick;

  // Divider clears and holds at zero while the module is off to save power
  always_comb begin
    div_nxt = 2'h0;
    if (cif.enable) begin
      div_nxt = (div_r == TRC_DIV_LAST) ? 2'h0 : div_r + 2'h1;
    end
    ext_prev_nxt = cif.ext_level;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 2'h0;
      ext_prev_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ext_prev_r <= ext_prev_nxt;
    end
  end

  assign div_tick = cif.enable && (div_r == TRC_DIV_LAST);

  // Source multiplexer; reserved code gives no tick at all
  always_comb begin
    pick = 1'b0;
    unique case (cif.sel)
      TRC_CK_SYS_DIV4: pick = div_tick;
      TRC_CK_SYS: pick = 1'b1;
      TRC_CK_HIGH_DIV16: pick = cif.high_div16_tick;
      TRC_CK_HIGH_DIV64: pick = cif.high_div64_tick;
      TRC_CK_TBC: pick = cif.tbc_tick;
      TRC_CK_RSVD: pick = 1'b0;
      TRC_CK_EXT_RISE: pick = cif.ext_level && !ext_prev_r;
      TRC_CK_EXT_FALL: pick = !cif.ext_level && ext_prev_r;
    endcase
  end

  assign cif.count_tick = cif.enable && pick;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_div4_tick;
    cif.count_tick && cif.sel == TRC_CK_SYS_DIV4;
  endsequence

  sequence s_div4_steady;
    (cif.sel == TRC_CK_SYS_DIV4 && cif.enable)[*4];
  endsequence

  chk_div4_spacing: assert property (
    s_div4_tick ##1 s_div4_steady |-> cif.count_tick &&
      !$past(cif.count_tick, 1) && !$past(cif.count_tick, 2) &&
      !$past(cif.count_tick, 3))
    else $error("divide by four tick spacing wrong");

  chk_sys_every: assert property (
    cif.enable && cif.sel == TRC_CK_SYS |-> cif.count_tick)
    else $error("system clock source missed a tick");

  chk_rsvd_none: assert property (
    cif.sel == TRC_CK_RSVD |-> !cif.count_tick)
    else $error("reserved source produced a tick");

  chk_ext_rise: assert property (
    cif.enable && cif.sel == TRC_CK_EXT_RISE |->
      cif.count_tick == (cif.ext_level && !$past(cif.ext_level)))
    else $error("external rising edge tick wrong");

  chk_ext_fall: assert property (
    cif.enable && cif.sel == TRC_CK_EXT_FALL |->
      cif.count_tick == (!cif.ext_level && $past(cif.ext_level)))
    else $error("external falling edge tick wrong");

endmodule // trc_clk_sel

/* File: core/trc_top.sv */
// Run control of a 16-bit standard timer: control register, counter
// with pause and on/off, and the compare output pin restore.
// Assumes internal clock ticks arrive as one-cycle pulses on clock,
// and the external count pin is asynchronous.
//
// Contract
// - Pause bit high holds the counter; clearing it lets counting go on.
// - Setting pause keeps the residual count instead of clearing it.
// - Releasing pause resumes counting from the held value.
// - Three-bit select picks sys/4, sys, high/16, high/64, time base, pin.
// - Counter runs only while the on/off bit is high.
// - Clearing on/off stops counting and enters the off state.
// - On/off rising resets the counter to zero.
// - On/off falling keeps the residual count until set again.
// - On/off rising in compare mode restores the pin's initial level.
`timescale 1ns/100ps

module trc_top import trc_pkg::*; (
  input wire logic clock, // 25 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [TRC_AW-1:0] reg_addr, // Register address
  input wire logic [TRC_DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [TRC_DW-1:0] reg_rdata, // Read data, one cycle later
  input wire logic high_div16_tick, // High clock /16 pulse
  input wire logic high_div64_tick, // High clock /64 pulse
  input wire logic time_base_tick, // Time-base clock pulse
  input wire logic external_count_pin, // Async external clock pin
  input wire logic output_toggle, // Compare match pulse
  output logic [TRC_CNT_W-1:0] counter_value, // Counter contents
  output logic timer_output, // Compare output pin level
  output logic module_active // High while module is on
);

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic ext_s1_r;
  logic ext_s2_r;

  // Only the second stage is read by logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_pin;
      ext_s2_r <= ext_s1_r;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [TRC_DW-1:0] run_r;
  logic [TRC_DW-1:0] run_nxt;
  logic [1:0] cfg_r;
  logic [1:0] cfg_nxt;
  logic pause;
  logic on;
  logic init_level;
  logic cmp_mode;
  logic wr_run;
  logic wr_cfg;

  assign wr_run = reg_wr && (reg_addr == TRC_OFS_RUN);
  assign wr_cfg = reg_wr && (reg_addr == TRC_OFS_OUT_CFG);

  // Unimplemented low bits never store, so they read as zero
  always_comb begin
    run_nxt = run_r;
    cfg_nxt = cfg_r;
    if (wr_run) begin
      run_nxt = reg_wdata & TRC_RUN_MASK;
    end
    if (wr_cfg) begin
      cfg_nxt = {reg_wdata[TRC_BIT_CMP], reg_wdata[TRC_BIT_INIT]};
    end
  end

  // Control state, cleared by reset to sys/4, off, running
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= TRC_RUN_RST;
      cfg_r <= TRC_CFG_RST;
    end else begin
      run_r <= run_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Field views of the stored control bits
  assign pause = run_r[TRC_BIT_PAUSE];
  assign on = run_r[TRC_BIT_ON];
  assign init_level = cfg_r[TRC_BIT_INIT];
  assign cmp_mode = cfg_r[TRC_BIT_CMP];

  // ****************************************
  // Count clock selection
  // ****************************************
  trc_clk_if cif ();

  // Same-clock pulses pass straight on; only the pin is synchronised
  assign cif.sel = trc_clk_sel_t'(run_r[TRC_BIT_SEL_HI:TRC_BIT_SEL_LO]);
  assign cif.enable = on;
  assign cif.high_div16_tick = high_div16_tick;
  assign cif.high_div64_tick = high_div64_tick;
  assign cif.tbc_tick = time_base_tick;
  assign cif.ext_level = ext_s2_r;

  trc_clk_sel u_clk_sel (
    .clock (clock),
    .rst_n (rst_n),
    .cif (cif.selector)
  );

  // ****************************************
  // Counter and output pin
  // ****************************************
  logic on_q_r;
  logic on_q_nxt;
  logic [TRC_CNT_W-1:0] cnt_r;
  logic [TRC_CNT_W-1:0] cnt_nxt;
  logic pin_r;
  logic pin_nxt;
  logic turn_on;
  logic advance;

  // Switch-on seen in the first cycle the on bit stands in the register
  assign turn_on = on && !on_q_r;
  // Pause keeps the module powered, only advance is blocked
  assign advance = on && !pause && cif.count_tick;

  // Clear on switch-on beats any tick in the same cycle
  always_comb begin
    on_q_nxt = on;
    cnt_nxt = cnt_r;
    if (turn_on) begin
      cnt_nxt = '0;
    end else if (advance) begin
      cnt_nxt = cnt_r + TRC_CNT_W'(1);
    end
  end

  // Restore wins over a coincident compare toggle
  always_comb begin
    pin_nxt = pin_r;
    if (turn_on && cmp_mode) begin
      pin_nxt = init_level;
    end else if (on && cmp_mode && output_toggle) begin
      pin_nxt = !pin_r;
    end
  end

  // Counter, switch-on history and pin level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_q_r <= 1'b0;
      cnt_r <= '0;
      pin_r <= 1'b0;
    end else begin
      on_q_r <= on_q_nxt;
      cnt_r <= cnt_nxt;
      pin_r <= pin_nxt;
    end
  end

  // Outputs come straight from flip-flops
  assign counter_value = cnt_r;
  assign timer_output = pin_r;
  assign module_active = on;

  // ****************************************
  // Read port
  // ****************************************
  logic [TRC_DW-1:0] rdata_r;
  logic [TRC_DW-1:0] rdata_nxt;

  // Data stand only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = TRC_RD_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        TRC_OFS_RUN: rdata_nxt = run_r;
        TRC_OFS_CNT_LO: rdata_nxt = cnt_r[TRC_DW-1:0];
        TRC_OFS_CNT_HI: rdata_nxt = cnt_r[TRC_CNT_W-1:TRC_DW];
        TRC_OFS_OUT_CFG: begin
          rdata_nxt[TRC_BIT_INIT] = init_level;
          rdata_nxt[TRC_BIT_CMP] = cmp_mode;
          rdata_nxt[TRC_BIT_PIN] = pin_r;
        end
        default: rdata_nxt = TRC_RD_ZERO;
      endcase
    end
  end

  // Read data register, zero whenever no read was made
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= TRC_RD_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data leave from a flip-flop
  assign reg_rdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // On bit dropped, then off for two more cycles
  sequence s_turned_off;
    $fell(on) ##1 !on [*2];
  endsequence

  // Pause released in a cycle that also carries a tick
  sequence s_pause_release;
    $fell(pause) ##0 (on && !turn_on && cif.count_tick);
  endsequence

  chk_pause_hold: assert property (
    on && pause && !turn_on |=> cnt_r == $past(cnt_r))
    else $error("counter moved while paused");

  chk_pause_keep: assert property (
    $rose(pause) && on && !turn_on |=> cnt_r == $past(cnt_r))
    else $error("pause entry changed the count");

  chk_resume_from: assert property (
    s_pause_release |=> cnt_r == $past(cnt_r) + TRC_CNT_W'(1))
    else $error("resume did not continue from held value");

  chk_run_step: assert property (
    advance && !turn_on |=> cnt_r == $past(cnt_r) + TRC_CNT_W'(1))
    else $error("running counter missed a tick");

  chk_off_stop: assert property (
    !on |=> cnt_r == $past(cnt_r))
    else $error("counter moved while off");

  chk_on_clear: assert property (
    wr_run && reg_wdata[TRC_BIT_ON] && !on ##1 1'b1 |=> cnt_r == '0)
    else $error("switch-on did not zero the counter");

  chk_off_keep: assert property (
    s_turned_off |-> cnt_r == $past(cnt_r, 2))
    else $error("switch-off lost the residual count");

  chk_pin_restore: assert property (
    turn_on && cmp_mode |=> timer_output == $past(init_level))
    else $error("pin not restored on switch-on");

  // ****************************************
  // Counter, pin and output config checks
  // ****************************************
  chk_clear_first: assert property (
    turn_on |=> cnt_r == '0)
    else $error("tick beat the switch-on clear");

  chk_rsvd_frozen: assert property (
    on && cif.sel == TRC_CK_RSVD && !turn_on |=> cnt_r == $past(cnt_r))
    else $error("counter moved on the reserved source");

  chk_pin_toggle: assert property (
    on && cmp_mode && output_toggle && !turn_on |=>
      timer_output != $past(timer_output))
    else $error("compare toggle did not flip the pin");

  chk_pin_idle: assert property (
    !(on && cmp_mode) |=> timer_output == $past(timer_output))
    else $error("pin moved outside compare operation");

  chk_cfg_keep: assert property (
    !wr_cfg |=> cfg_r == $past(cfg_r))
    else $error("output config changed without a write");

  // ****************************************
  // Register port and pin input checks
  // ****************************************
  chk_read_once: assert property (
    !reg_rd |=> reg_rdata == TRC_RD_ZERO)
    else $error("read data stood past its cycle");

  chk_read_run: assert property (
    reg_rd && reg_addr == TRC_OFS_RUN |=> reg_rdata == $past(run_r))
    else $error("run register read back wrong");

  chk_read_count: assert property (
    reg_rd && reg_addr == TRC_OFS_CNT_HI |=>
      reg_rdata == $past(cnt_r[TRC_CNT_W-1:TRC_DW]))
    else $error("count high byte read back wrong");

  chk_run_spare: assert property (
    (run_r & ~TRC_RUN_MASK) == TRC_RD_ZERO)
    else $error("unimplemented run bits stored a one");

  // Reset empties both stages, so wait until they have refilled
  chk_sync_depth: assert property (
    $past(rst_n, 2) |-> ext_s2_r == $past(external_count_pin, 2))
    else $error("pin synchroniser depth wrong");

endmodule // trc_top

/* File: tb/trc_top_bench.sv */
// Self-checking bench for the timer run-control block: register port,
// count clock selection, pause, on/off and compare pin restore.
// Assumes the design is reached only through its top-level ports.
`timescale 1ns/100ps

module trc_top_bench;
  import trc_pkg::*;

  // ****************************************
  // Signals and counters
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [TRC_AW-1:0] reg_addr = 8'h00;
  logic [TRC_DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [TRC_DW-1:0] reg_rdata;
  logic high_div16_tick = 1'b0;
  logic high_div64_tick = 1'b0;
  logic time_base_tick = 1'b0;
  logic external_count_pin = 1'b0;
  logic output_toggle = 1'b0;
  logic [TRC_CNT_W-1:0] counter_value;
  logic timer_output;
  logic module_active;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [TRC_DW-1:0] d;
  logic [TRC_CNT_W-1:0] v;
  trc_clk_sel_t row_sel [8];
  logic [TRC_CNT_W-1:0] row_exp [8];

  trc_top uut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .high_div16_tick(high_div16_tick),
    .high_div64_tick(high_div64_tick), .time_base_tick(time_base_tick),
    .external_count_pin(external_count_pin),
    .output_toggle(output_toggle), .counter_value(counter_value),
    .timer_output(timer_output), .module_active(module_active)
  );

  // 40 ns period
  always #20 clock = ~clock;

  // ****************************************
  // Tick sources and hang guard
  // ****************************************
  // Periods divide 32, so any 32-cycle window sees a fixed tick count
  always @(posedge clock) begin
    cyc <= cyc + 1;
    high_div16_tick <= (cyc[0] == 1'b0);
    high_div64_tick <= (cyc[2:0] == 3'h0);
    time_base_tick <= (cyc[3:0] == 4'h0);
    external_count_pin <= cyc[3];
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait n edges, then settle past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data is taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] rd_d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_d = reg_rdata;
  endtask

  task automatic stop_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    row_sel = '{TRC_CK_SYS_DIV4, TRC_CK_SYS, TRC_CK_HIGH_DIV16,
                TRC_CK_HIGH_DIV64, TRC_CK_TBC, TRC_CK_RSVD,
                TRC_CK_EXT_RISE, TRC_CK_EXT_FALL};
    row_exp = '{16'h0008, 16'h0020, 16'h0010, 16'h0004, 16'h0002,
                16'h0000, 16'h0002, 16'h0002};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values and register port
    tick(1);
    chk(counter_value, 16'h0);
    chk(16'(timer_output), 16'h0);
    chk(16'(module_active), 16'h0);
    rd(TRC_OFS_RUN, d);
    chk(16'(d), 16'(TRC_RUN_RST));
    rd(TRC_OFS_OUT_CFG, d);
    chk(16'(d), 16'h0);
    wr(TRC_OFS_RUN, 8'hff);
    rd(TRC_OFS_RUN, d);
    chk(16'(d), 16'h00f8);
    rd(8'h7f, d);
    chk(16'(d), 16'h0);
    tick(1);
    chk(16'(reg_rdata), 16'h0);
    // Each select code: clear on switch-on, then ticks in 32 cycles
    for (int i = 0; i < 8; i++) begin
      wr(TRC_OFS_RUN, 8'h00);
      wr(TRC_OFS_RUN, {1'b0, row_sel[i], 4'h8});
      tick(1);
      chk(counter_value, 16'h0);
      chk(16'(module_active), 16'h1);
      v = counter_value;
      tick(32);
      chk(counter_value - v, row_exp[i]);
    end
    // Pause holds the residual count, release resumes from it
    wr(TRC_OFS_RUN, 8'h18);
    tick(5);
    wr(TRC_OFS_RUN, 8'h98);
    tick(2);
    v = counter_value;
    chk(16'(v != 16'h0), 16'h1);
    tick(10);
    chk(counter_value, v);
    wr(TRC_OFS_RUN, 8'h18);
    tick(3);
    chk(counter_value - v, 16'h0003);
    // Switch off keeps the count and drops the active flag
    wr(TRC_OFS_RUN, 8'h10);
    tick(2);
    v = counter_value;
    chk(16'(module_active), 16'h0);
    tick(10);
    chk(counter_value, v);
    // Count registers are read-only
    wr(TRC_OFS_CNT_LO, 8'h55);
    rd(TRC_OFS_CNT_LO, d);
    chk(16'(d), 16'(v[7:0]));
    rd(TRC_OFS_CNT_HI, d);
    chk(16'(d), 16'(v[15:8]));
    // Compare pin returns to its initial level on switch-on
    wr(TRC_OFS_OUT_CFG, 8'h02);
    wr(TRC_OFS_RUN, 8'h08);
    tick(2);
    @(posedge clock);
    output_toggle <= 1'b1;
    @(posedge clock);
    output_toggle <= 1'b0;
    tick(2);
    chk(16'(timer_output), 16'h1);
    wr(TRC_OFS_RUN, 8'h00);
    wr(TRC_OFS_RUN, 8'h08);
    tick(2);
    chk(16'(timer_output), 16'h0);
    wr(TRC_OFS_OUT_CFG, 8'h03);
    wr(TRC_OFS_RUN, 8'h00);
    wr(TRC_OFS_RUN, 8'h08);
    tick(2);
    chk(16'(timer_output), 16'h1);
    rd(TRC_OFS_OUT_CFG, d);
    chk(16'(d), 16'h0007);
    stop_test();
  end

endmodule // trc_top_bench
